/* logic/safing_defs.vh */
// offsets, fields, reset values and timing defaults of the safing and disposal block
// Notes on behaviour
// - Safing reset holds record processing, counters and arming decisions inactive.
// - Sixteen records share common steps and arming thresholds, each fed its own samples.
// - Sample above threshold or below its negation adds step to matching counter.
// - Sample inside both thresholds subtracts the separate subtract step.
// - Separate positive and negative counters, same steps, both updated per sample.
// - Counters compared with arming thresholds set or clear positive/negative arm flags.
// - Arming threshold zero arms immediately on entering safing state.
// - Counters freeze when compare-complete bits stop being read; host must keep reading.
// - Each internal arming signal is OR of armed, enabled mapped records.
// - Diagnostic arming-pin test and rail test never run together.
// - Per-loop mask selects arming signals; unmasked active signal enables loop.
// - Any arming signal enables rail; safing transistor also needs host signal.
// - Four arming output pins reflect the arming state.
// - Started dwell runs on despite record disable; safing reset cuts it.
// - Per-output dwell counter loads only a longer request; never shortened.
// - Free-running 8-bit seed; reading it captures its value and computes key.
// - Expected key is frozen seed XOR 0x55; host submits exactly that.
// - Scrap to arming needs two good handshakes plus qualified disposal line.
// - Arming state drives all pins and rail; wrong key, timeout, line loss revert.
// - Disposal line qualified by period and duty; three good keep, two bad drop.
// - Bad disposal line keeps the once state on a good second key, or leaves arming state at once.
// - Armed record with compare-complete set ignores samples until register read.
// - Safing reset clears all programmed records to defaults.
`ifndef SAFING_DEFS_VH
`define SAFING_DEFS_VH
`define OFS_REC_SEL 8'h00
`define OFS_REC_CTRL 8'h04
`define OFS_REC_TH 8'h08
`define OFS_STEPS 8'h0C
`define OFS_ARM_TH 8'h10
`define OFS_CC 8'h14
`define OFS_LOOP_MASK 8'h18
`define OFS_DIAG_TEST 8'h1C
`define OFS_STATUS 8'h20
`define OFS_SEED 8'h24
`define OFS_KEY 8'h28
`define OFS_COUNTERS 8'h2C
`define CTRL_EN 0
`define CTRL_MAP_LSB 1
`define CTRL_DWELL_LSB 8
`define DIAG_ARM_TEST 0
`define DIAG_RAIL_TEST 1
`define DIAG_PAT_LSB 4
`define KEY_XOR 8'h55
`define ACL_GOOD_NEEDED 2'h3
`define ACL_BAD_LIMIT 2'h2
`define STEP_RESET 8'h01
`define ARM_TH_RESET 8'h01
`define CC_READ_LIMIT 1000
`define DWELL_TICK_CYC 1000
`define SEED_DIV_CYC 100
`define SCRAP_TIMEOUT_CYC 100000
`define ACL_PER_MIN 1000
`define ACL_PER_MAX 3000
`define ACL_HI_MIN 300
`define ACL_HI_MAX 1200
`endif

/* logic/safing_arming.v */
// safing arming engine with dwell stretch, loop masks and end-of-life disposal arming
`timescale 1ns/1ps
`default_nettype none
`include "safing_defs.vh"
module safing_arming #(
  parameter NLOOP = 8,
  parameter [15:0] CC_READ_LIMIT = `CC_READ_LIMIT,
  parameter [15:0] DWELL_TICK_CYC = `DWELL_TICK_CYC,
  parameter [15:0] SEED_DIV_CYC = `SEED_DIV_CYC,
  parameter [23:0] SCRAP_TIMEOUT_CYC = `SCRAP_TIMEOUT_CYC,
  parameter [15:0] ACL_PER_MIN = `ACL_PER_MIN,
  parameter [15:0] ACL_PER_MAX = `ACL_PER_MAX,
  parameter [15:0] ACL_HI_MIN = `ACL_HI_MIN,
  parameter [15:0] ACL_HI_MAX = `ACL_HI_MAX
) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire ssm_reset,
  input wire safing_state,
  input wire diag_state,
  input wire scrap_mode,
  input wire sample_valid,
  input wire [3:0] sample_record,
  input wire [15:0] sample_data,
  input wire disposal_line_input,
  input wire safing_fet_request,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  output reg [3:0] arming_output_pin,
  output reg safing_rail_enable,
  output reg safing_fet_on,
  output reg [NLOOP-1:0] loop_enable
);

  localparam [2:0] ST_SCRAP = 3'b001;
  localparam [2:0] ST_ONCE = 3'b010;
  localparam [2:0] ST_ARMED = 3'b100;

  function [7:0] sadd;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sadd = s[8] ? 8'hFF : s[7:0];
    end
  endfunction

  function [7:0] ssub;
    input [7:0] a;
    input [7:0] b;
    begin
      ssub = (a < b) ? 8'h00 : a - b;
    end
  endfunction

  // bus: side effects of reads happen at the address phase edge
  wire addr_ok = hsel && hready && htrans[1];
  wire rd_now = addr_ok && !hwrite;
  wire [7:0] ra = haddr[7:0];
  wire rd_cc = rd_now && (ra == `OFS_CC);
  wire rd_seed = rd_now && (ra == `OFS_SEED);

  reg wr_pend;
  reg [7:0] wr_addr;
  wire w_sel = wr_pend && (wr_addr == `OFS_REC_SEL);
  wire w_ctrl = wr_pend && (wr_addr == `OFS_REC_CTRL);
  wire w_th = wr_pend && (wr_addr == `OFS_REC_TH);
  wire w_steps = wr_pend && (wr_addr == `OFS_STEPS);
  wire w_armth = wr_pend && (wr_addr == `OFS_ARM_TH);
  wire w_mask = wr_pend && (wr_addr == `OFS_LOOP_MASK);
  wire w_diag = wr_pend && (wr_addr == `OFS_DIAG_TEST);
  wire w_key = wr_pend && (wr_addr == `OFS_KEY);

  reg [3:0] rec_sel;
  reg [7:0] add_step;
  reg [7:0] sub_step;
  reg [7:0] pos_arm_th;
  reg [7:0] neg_arm_th;
  reg [4*NLOOP-1:0] loop_mask;
  reg arm_test;
  reg rail_test;
  reg [3:0] arm_pattern;
  reg [15:0] cc_idle;
  wire cc_frozen = (cc_idle == CC_READ_LIMIT);

  wire [15:0] rec_en_vec;
  wire [15:0] armed_vec;
  wire [15:0] cc_vec;
  wire [63:0] map_flat;
  wire [127:0] dwell_flat;
  wire [255:0] th_flat;
  wire [127:0] pcnt_flat;
  wire [127:0] ncnt_flat;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rec_sel <= 4'h0;
      add_step <= `STEP_RESET;
      sub_step <= `STEP_RESET;
      pos_arm_th <= `ARM_TH_RESET;
      neg_arm_th <= `ARM_TH_RESET;
      loop_mask <= {4*NLOOP{1'b0}};
      arm_test <= 1'b0;
      rail_test <= 1'b0;
      arm_pattern <= 4'h0;
      cc_idle <= 16'h0000;
    end else if (clk_en) begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= ra;
      if (w_sel) begin
        rec_sel <= hwdata[3:0];
      end
      if (ssm_reset) begin
        add_step <= `STEP_RESET;
        sub_step <= `STEP_RESET;
        pos_arm_th <= `ARM_TH_RESET;
        neg_arm_th <= `ARM_TH_RESET;
      end else if (diag_state) begin
        if (w_steps) begin
          add_step <= hwdata[7:0];
          sub_step <= hwdata[15:8];
        end
        if (w_armth) begin
          pos_arm_th <= hwdata[7:0];
          neg_arm_th <= hwdata[15:8];
        end
      end
      if (w_mask) begin
        loop_mask <= hwdata[4*NLOOP-1:0];
      end
      if (w_diag) begin
        arm_test <= hwdata[`DIAG_ARM_TEST];
        // arming-pin test takes precedence over a simultaneous rail test
        rail_test <= hwdata[`DIAG_RAIL_TEST] && !hwdata[`DIAG_ARM_TEST];
        arm_pattern <= hwdata[`DIAG_PAT_LSB+3:`DIAG_PAT_LSB];
      end
      if (ssm_reset || rd_cc || !safing_state) begin
        cc_idle <= 16'h0000;
      end else if (!cc_frozen) begin
        cc_idle <= cc_idle + 16'h0001;
      end
    end
  end

  // one record per generate entry
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : rec
      localparam integer IDX = g;
      reg en;
      reg [3:0] map;
      reg [7:0] dwell;
      reg [15:0] th;
      reg [7:0] pc;
      reg [7:0] nc;
      reg cc;
      wire wsel = (rec_sel == IDX);
      wire signed [16:0] sx = {sample_data[15], sample_data};
      wire signed [16:0] thx = {1'b0, th};
      wire signed [16:0] nthx = 17'sd0 - thx;
      wire pev = sx > thx;
      wire nev = sx < nthx;
      wire hit = sample_valid && (sample_record == IDX) && en && safing_state && !cc && !cc_frozen;
      wire [7:0] pn = pev ? sadd(pc, add_step) : ssub(pc, sub_step);
      wire [7:0] nn = nev ? sadd(nc, add_step) : ssub(nc, sub_step);
      wire pflag = safing_state && (pc >= pos_arm_th);
      wire nflag = safing_state && (nc >= neg_arm_th);
      wire armed_after = en && ((pn >= pos_arm_th) || (nn >= neg_arm_th));
      assign armed_vec[g] = en && !ssm_reset && (pflag || nflag);
      assign rec_en_vec[g] = en;
      assign cc_vec[g] = cc;
      assign map_flat[4*g+3:4*g] = map;
      assign dwell_flat[8*g+7:8*g] = dwell;
      assign th_flat[16*g+15:16*g] = th;
      assign pcnt_flat[8*g+7:8*g] = pc;
      assign ncnt_flat[8*g+7:8*g] = nc;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          en <= 1'b0;
          map <= 4'h0;
          dwell <= 8'h00;
          th <= 16'h0000;
          pc <= 8'h00;
          nc <= 8'h00;
          cc <= 1'b0;
        end else if (clk_en) begin
          if (ssm_reset) begin
            en <= 1'b0;
            map <= 4'h0;
            dwell <= 8'h00;
            th <= 16'h0000;
            pc <= 8'h00;
            nc <= 8'h00;
            cc <= 1'b0;
          end else begin
            if (w_ctrl && wsel) begin
              en <= hwdata[`CTRL_EN];
              if (diag_state) begin
                map <= hwdata[`CTRL_MAP_LSB+3:`CTRL_MAP_LSB];
                dwell <= hwdata[`CTRL_DWELL_LSB+7:`CTRL_DWELL_LSB];
              end
            end
            if (w_th && wsel && diag_state) begin
              th <= hwdata[15:0];
            end
            if (hit) begin
              pc <= pn;
              nc <= nn;
            end
            // a new completion wins over a read in the same cycle
            cc <= (hit && armed_after) || (cc && !rd_cc);
          end
        end
      end
    end
  endgenerate

  // shared dwell tick
  reg [15:0] tick_cnt;
  wire tick = (tick_cnt == DWELL_TICK_CYC - 16'h0001);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 16'h0000;
    end else if (clk_en) begin
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  // one dwell counter per arming output
  wire [3:0] int_sig;
  wire [3:0] stretched;
  wire [3:0] dwell_active;
  genvar j;
  generate
    for (j = 0; j < 4; j = j + 1) begin : arm
      reg [7:0] req;
      reg hit_any;
      reg [7:0] dc;
      always @* begin : pick
        integer r;
        r = 0;
        req = 8'h00;
        hit_any = 1'b0;
        for (r = 0; r < 16; r = r + 1) begin
          if (armed_vec[r] && map_flat[4*r+j]) begin
            hit_any = 1'b1;
            if (dwell_flat[8*r +: 8] > req) begin
              req = dwell_flat[8*r +: 8];
            end
          end
        end
      end
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dc <= 8'h00;
        end else if (clk_en) begin
          if (ssm_reset) begin
            dc <= 8'h00;
          end else if (dc < req) begin
            dc <= req;
          end else if (tick && (dc != 8'h00)) begin
            dc <= dc - 8'h01;
          end
        end
      end
      assign int_sig[j] = hit_any;
      assign dwell_active[j] = (dc != 8'h00);
      assign stretched[j] = hit_any || (dc != 8'h00);
    end
  endgenerate

  // disposal line qualification
  reg acl_d;
  reg [15:0] per_cnt;
  reg [15:0] hi_cnt;
  reg [1:0] good_cnt;
  reg [1:0] bad_cnt;
  wire acl_rise = disposal_line_input && !acl_d;
  wire acl_lost = (per_cnt == ACL_PER_MAX);
  wire acl_valid = acl_rise && (per_cnt >= ACL_PER_MIN) && (hi_cnt >= ACL_HI_MIN) && (hi_cnt <= ACL_HI_MAX);
  wire acl_ok = (good_cnt == `ACL_GOOD_NEEDED);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acl_d <= 1'b0;
      per_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
      good_cnt <= 2'h0;
      bad_cnt <= 2'h0;
    end else if (clk_en) begin
      acl_d <= disposal_line_input;
      if (!scrap_mode || ssm_reset) begin
        per_cnt <= 16'h0000;
        hi_cnt <= 16'h0000;
        good_cnt <= 2'h0;
        bad_cnt <= 2'h0;
      end else if (acl_rise || acl_lost) begin
        per_cnt <= 16'h0000;
        hi_cnt <= 16'h0000;
        if (acl_valid) begin
          bad_cnt <= 2'h0;
          if (!acl_ok) begin
            good_cnt <= good_cnt + 2'h1;
          end
        end else if (bad_cnt + 2'h1 >= `ACL_BAD_LIMIT) begin
          bad_cnt <= `ACL_BAD_LIMIT;
          good_cnt <= 2'h0;
        end else begin
          bad_cnt <= bad_cnt + 2'h1;
        end
      end else begin
        per_cnt <= per_cnt + 16'h0001;
        if (disposal_line_input) begin
          hi_cnt <= hi_cnt + 16'h0001;
        end
      end
    end
  end

  // seed, key and scrap state machine
  reg [15:0] seed_div;
  reg [7:0] seed_cnt;
  reg [7:0] key_exp;
  reg key_valid;
  reg [2:0] st;
  reg [23:0] to_cnt;
  wire key_match = key_valid && (hwdata[7:0] == key_exp);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seed_div <= 16'h0000;
      seed_cnt <= 8'h00;
      key_exp <= 8'h00;
      key_valid <= 1'b0;
      st <= ST_SCRAP;
      to_cnt <= 24'h000000;
    end else if (clk_en) begin
      if (seed_div == SEED_DIV_CYC - 16'h0001) begin
        seed_div <= 16'h0000;
        seed_cnt <= seed_cnt + 8'h01;
      end else begin
        seed_div <= seed_div + 16'h0001;
      end
      if (rd_seed) begin
        key_exp <= seed_cnt ^ `KEY_XOR;
        key_valid <= 1'b1;
      end else if (w_key && (st != ST_ARMED)) begin
        key_valid <= 1'b0;
      end
      if (!scrap_mode || ssm_reset) begin
        st <= ST_SCRAP;
        to_cnt <= 24'h000000;
      end else begin
        case (st)
          ST_SCRAP: begin
            if (w_key && key_match) begin
              st <= ST_ONCE;
            end
          end
          ST_ONCE: begin
            if (w_key && !key_match) begin
              st <= ST_SCRAP;
            end else if (w_key && acl_ok) begin
              st <= ST_ARMED;
              to_cnt <= SCRAP_TIMEOUT_CYC;
            end
          end
          ST_ARMED: begin
            if ((w_key && !key_match) || !acl_ok || (to_cnt == 24'h000000)) begin
              st <= ST_SCRAP;
            end else if (w_key) begin
              to_cnt <= SCRAP_TIMEOUT_CYC;
            end else begin
              to_cnt <= to_cnt - 24'h000001;
            end
          end
          default: begin
            st <= ST_SCRAP;
          end
        endcase
      end
    end
  end

  // output drive
  wire disp_armed = (st == ST_ARMED);
  wire run_arm_test = diag_state && arm_test;
  wire run_rail_test = diag_state && rail_test && !arm_test;
  reg [3:0] pins_next;
  reg rail_next;
  reg [NLOOP-1:0] loops_next;
  always @* begin : drive
    integer k;
    k = 0;
    if (disp_armed) begin
      pins_next = 4'hF;
    end else if (run_arm_test) begin
      pins_next = arm_pattern;
    end else begin
      pins_next = stretched;
    end
    rail_next = disp_armed || (|stretched) || run_rail_test;
    for (k = 0; k < NLOOP; k = k + 1) begin
      loops_next[k] = disp_armed || (|(stretched & ~loop_mask[4*k +: 4]));
    end
  end

  reg [31:0] rd_next;
  always @* begin
    rd_next = 32'h00000000;
    if (ra == `OFS_REC_SEL) begin
      rd_next = {28'h0000000, rec_sel};
    end else if (ra == `OFS_REC_CTRL) begin
      rd_next = {16'h0000, dwell_flat[8*rec_sel +: 8], 3'h0, map_flat[4*rec_sel +: 4], rec_en_vec[rec_sel]};
    end else if (ra == `OFS_REC_TH) begin
      rd_next = {16'h0000, th_flat[16*rec_sel +: 16]};
    end else if (ra == `OFS_STEPS) begin
      rd_next = {16'h0000, sub_step, add_step};
    end else if (ra == `OFS_ARM_TH) begin
      rd_next = {16'h0000, neg_arm_th, pos_arm_th};
    end else if (ra == `OFS_CC) begin
      rd_next = {16'h0000, cc_vec};
    end else if (ra == `OFS_LOOP_MASK) begin
      rd_next[4*NLOOP-1:0] = loop_mask;
    end else if (ra == `OFS_DIAG_TEST) begin
      rd_next = {24'h000000, arm_pattern, 2'h0, rail_test, arm_test};
    end else if (ra == `OFS_STATUS) begin
      rd_next = {14'h0000, cc_frozen, acl_ok, st, safing_rail_enable, arming_output_pin, dwell_active, int_sig};
    end else if (ra == `OFS_SEED) begin
      rd_next = {24'h000000, seed_cnt};
    end else if (ra == `OFS_COUNTERS) begin
      rd_next = {16'h0000, ncnt_flat[8*rec_sel +: 8], pcnt_flat[8*rec_sel +: 8]};
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      arming_output_pin <= 4'h0;
      safing_rail_enable <= 1'b0;
      safing_fet_on <= 1'b0;
      loop_enable <= {NLOOP{1'b0}};
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_now) begin
        hrdata <= rd_next;
      end
      arming_output_pin <= pins_next;
      safing_rail_enable <= rail_next;
      safing_fet_on <= rail_next && safing_fet_request;
      loop_enable <= loops_next;
    end
  end

endmodule // safing_arming
`default_nettype wire

/* verification/arm_chk.sv */
// concurrent checks on the port behaviour of the safing arming block
`timescale 1ns/1ps
`default_nettype none
module arm_chk #(
  parameter NLOOP = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ssm_reset,
  input wire logic diag_state,
  input wire logic safing_fet_request,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [3:0] arming_output_pin,
  input wire logic safing_rail_enable,
  input wire logic safing_fet_on,
  input wire logic [NLOOP-1:0] loop_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd_at(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence
  sequence s_no_diag;
    (!diag_state)[*2];
  endsequence
  property p_unmapped; s_rd_at(8'h40) |=> hrdata == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_seed_width; s_rd_at(8'h24) |=> hrdata[31:8] == 24'h000000; endproperty
  a_seed_width: assert property (p_seed_width) else $error("seed wider than 8 bits");
  property p_rd_hold; !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_ready; $past(hresetn) |-> hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("slave not ready");
  property p_ssm_quiet; (ssm_reset && !diag_state)[*2] |=> arming_output_pin == 4'h0 && !safing_rail_enable; endproperty
  a_ssm_quiet: assert property (p_ssm_quiet) else $error("arming active in safing reset");
  property p_fet_rail; safing_fet_on |-> safing_rail_enable; endproperty
  a_fet_rail: assert property (p_fet_rail) else $error("fet on without rail");
  property p_fet_req; safing_fet_on |-> $past(safing_fet_request); endproperty
  a_fet_req: assert property (p_fet_req) else $error("fet on without request");
  property p_loop; s_no_diag ##0 (loop_enable != 0) |-> arming_output_pin != 4'h0; endproperty
  a_loop: assert property (p_loop) else $error("loop enabled without arming");
  property p_rail; s_no_diag |-> safing_rail_enable == (arming_output_pin != 4'h0); endproperty
  a_rail: assert property (p_rail) else $error("rail does not follow arming");
endmodule // arm_chk
bind safing_arming arm_chk #(.NLOOP(NLOOP)) u_chk (.hclk(hclk), .hresetn(hresetn), .ssm_reset(ssm_reset),
  .diag_state(diag_state), .safing_fet_request(safing_fet_request), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .arming_output_pin(arming_output_pin), .safing_rail_enable(safing_rail_enable), .safing_fet_on(safing_fet_on),
  .loop_enable(loop_enable));
`default_nettype wire

/* verification/disposal_source.sv */
// disposal line source: periodic pulse train, held low when stopped
`timescale 1ns/1ps
`default_nettype none
module disposal_source (
  input wire logic hclk,
  input wire logic run,
  input wire logic [7:0] period,
  input wire logic [7:0] high_time,
  output logic line
);
  logic [7:0] cnt_reg;
  always @(posedge hclk) begin
    if (!run || cnt_reg >= period - 8'h01) begin
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
    line <= run && (cnt_reg < high_time);
  end
endmodule // disposal_source
`default_nettype wire

/* verification/tb.sv */
// self-checking bench for the safing arming block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ssm_reset = 1'b0, safing_state = 1'b0, diag_state = 1'b0, scrap_mode = 1'b0, fet_req = 1'b0;
  logic sample_valid = 1'b0, clk_en = 1'b1;
  logic [3:0] srec = 4'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] per = 8'h14, hi = 8'h08;
  logic [15:0] sample_data = 16'h0000;
  logic hsel = 1'b0, hwrite = 1'b0, dp_rd = 1'b0, line_run = 1'b0;
  logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, rdata, rnd = 32'h3B245AD0;
  logic [1:0] htrans = 2'h0;
  logic [63:0] e;
  logic [63:0] q[$];
  wire logic line, hreadyout, hresp, rail, fet_on;
  wire logic [31:0] hrdata;
  wire logic [3:0] pins;
  wire logic [7:0] loops;
  int miscompares = 0;
  int total_checks = 0;
  always #5 hclk = ~hclk;
  safing_arming #(.DWELL_TICK_CYC(16'h0004), .SCRAP_TIMEOUT_CYC(24'h0000C8), .ACL_PER_MIN(16'h000A),
    .ACL_PER_MAX(16'h001E), .ACL_HI_MIN(16'h0003)) DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .ssm_reset(ssm_reset), .safing_state(safing_state), .diag_state(diag_state), .scrap_mode(scrap_mode),
    .sample_valid(sample_valid), .sample_record(srec), .sample_data(sample_data), .disposal_line_input(line),
    .safing_fet_request(fet_req), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .arming_output_pin(pins),
    .safing_rail_enable(rail), .safing_fet_on(fet_on), .loop_enable(loops));
  disposal_source u_line (.hclk(hclk), .run(line_run), .period(per), .high_time(hi), .line(line));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic waitrdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        miscompares++;
        end_of_test;
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    waitrdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    dp_rd <= !w;
    waitrdy;
    rdata = hrdata;
    dp_rd <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    q.push_back({m, exp});
    bus(a, 1'b0, 32'h00000000);
  endtask
  // read results are compared when their data phase completes
  always @(posedge hclk) begin
    if (dp_rd && hreadyout === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      cmp(hrdata & e[63:32], e[31:0] & e[63:32]);
    end
  end
  task automatic sample(input logic [15:0] d);
    sample_valid <= 1'b1;
    sample_data <= d;
    @(posedge hclk);
    sample_valid <= 1'b0;
    rnd = lfsr(rnd);
    @(posedge hclk);
  endtask
  task automatic wait_pins(input logic [3:0] exp);
    int n;
    n = 0;
    while (pins !== exp && n < 300) begin
      n++;
      @(posedge hclk);
    end
    cmp({28'h0000000, pins}, {28'h0000000, exp});
    if (n >= 300) end_of_test;
  endtask
  task automatic hand(input logic good);
    rd(8'h24, 32'h00000000, 32'hFFFFFF00);
    bus(8'h28, 1'b1, {24'h000000, rdata[7:0] ^ (good ? 8'h55 : 8'h54)});
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(8'h0C, 32'h00000101, 32'hFFFFFFFF);
    rd(8'h40, 32'h00000000, 32'hFFFFFFFF);
    diag_state <= 1'b1;
    bus(8'h00, 1'b1, 32'h00000000);
    bus(8'h04, 1'b1, 32'h00000303);
    bus(8'h08, 1'b1, 32'h00000064);
    bus(8'h0C, 1'b1, 32'h00000103);
    bus(8'h10, 1'b1, 32'h00000909);
    bus(8'h18, 1'b1, 32'h00000000);
    diag_state <= 1'b0;
    safing_state <= 1'b1;
    rd(8'h14, 32'h00000000, 32'hFFFFFFFF);
    sample(16'h00C8);
    sample(16'hFF38);
    sample({10'h000, rnd[5:0]});
    srec <= 4'h1;
    sample(16'h00C8);
    srec <= 4'h0;
    rd(8'h2C, 32'h00000201, 32'hFFFFFFFF);
    repeat (1000) @(posedge hclk);
    sample(16'h00C8);
    rd(8'h2C, 32'h00000201, 32'hFFFFFFFF);
    rd(8'h14, 32'h00000000, 32'hFFFFFFFF);
    repeat (3) sample(16'h00C8);
    wait_pins(4'h1);
    @(posedge hclk);
    cmp({24'h000000, loops}, 32'h000000FF);
    sample(16'hFF38);
    rd(8'h2C, 32'h0000000A, 32'hFFFFFFFF);
    rd(8'h14, 32'h00000001, 32'hFFFFFFFF);
    repeat (2) sample({10'h000, rnd[5:0]});
    bus(8'h04, 1'b1, 32'h00000000);
    repeat (2) @(posedge hclk);
    cmp({28'h0000000, pins}, 32'h00000001);
    clk_en <= 1'b0;
    repeat (40) @(posedge hclk);
    cmp({28'h0000000, pins}, 32'h00000001);
    clk_en <= 1'b1;
    wait_pins(4'h0);
    ssm_reset <= 1'b1;
    repeat (3) @(posedge hclk);
    ssm_reset <= 1'b0;
    rd(8'h10, 32'h00000101, 32'hFFFFFFFF);
    rd(8'h2C, 32'h00000000, 32'hFFFFFFFF);
    safing_state <= 1'b0;
    diag_state <= 1'b1;
    bus(8'h1C, 1'b1, 32'h000000A3);
    rd(8'h1C, 32'h000000A1, 32'hFFFFFFFF);
    wait_pins(4'hA);
    cmp({31'h00000000, rail}, 32'h00000000);
    bus(8'h1C, 1'b1, 32'h00000002);
    wait_pins(4'h0);
    cmp({31'h00000000, rail}, 32'h00000001);
    bus(8'h1C, 1'b1, 32'h00000000);
    bus(8'h04, 1'b1, 32'h00000009);
    bus(8'h10, 1'b1, 32'h00000000);
    bus(8'h18, 1'b1, 32'h00000004);
    diag_state <= 1'b0;
    safing_state <= 1'b1;
    wait_pins(4'h4);
    cmp({24'h000000, loops}, 32'h000000FE);
    fet_req <= 1'b1;
    repeat (2) @(posedge hclk);
    cmp({31'h00000000, fet_on}, 32'h00000001);
    fet_req <= 1'b0;
    ssm_reset <= 1'b1;
    safing_state <= 1'b0;
    wait_pins(4'h0);
    ssm_reset <= 1'b0;
    scrap_mode <= 1'b1;
    line_run <= 1'b1;
    repeat (80) @(posedge hclk);
    hand(1'b1);
    repeat (20) @(posedge hclk);
    cmp({28'h0000000, pins}, 32'h00000000);
    hand(1'b1);
    wait_pins(4'hF);
    cmp({31'h00000000, rail}, 32'h00000001);
    rd(8'h20, 32'h00019F00, 32'hFFFFFFFF);
    repeat (150) @(posedge hclk);
    hand(1'b1);
    repeat (100) @(posedge hclk);
    cmp({28'h0000000, pins}, 32'h0000000F);
    hand(1'b0);
    wait_pins(4'h0);
    hand(1'b1);
    hand(1'b1);
    wait_pins(4'hF);
    wait_pins(4'h0);
    hand(1'b1);
    hand(1'b1);
    wait_pins(4'hF);
    line_run <= 1'b0;
    repeat (100) @(posedge hclk);
    cmp({28'h0000000, pins}, 32'h00000000);
    hand(1'b1);
    hand(1'b1);
    repeat (20) @(posedge hclk);
    cmp({28'h0000000, pins}, 32'h00000000);
    line_run <= 1'b1;
    hi <= 8'h01;
    repeat (100) @(posedge hclk);
    hand(1'b1);
    hand(1'b1);
    repeat (2) @(posedge hclk);
    cmp({28'h0000000, pins}, 32'h00000000);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
